// ### pkg/overlay_pkg.sv
// constants and carrier types of the configuration overlay checker
// assumes a single core clock; every other party sits on the same clock
package overlay_pkg;
	localparam int WORD_W = 16; // overlay word width
	localparam int OVL_DEPTH = 256; // words per overlay
	localparam int ADDR_W = 8; // word index width
	localparam int LBA_W = 28; // sector address width
	localparam logic [7:0] LAST_WORD = 8'hff; // integrity word index
	localparam logic [7:0] FEAT_WORD = 8'h07; // feature word index
	localparam logic [7:0] SIG_CODE = 8'ha5; // structure signature
	localparam logic [7:0] NO_WORD = 8'h00; // index when nothing refused
	localparam int BIT_LBA48 = 8; // large addressing flag
	localparam int BIT_HPA = 7; // protected area flag
	localparam int BIT_AAM = 6; // acoustic management flag
	localparam int BIT_QDMA = 5; // queued dma flag
	localparam int BIT_PUIS = 4; // power-up in standby flag
	localparam int BIT_SEC = 3; // security flag
	localparam int BIT_LOG = 2; // smart error log flag
	localparam int BIT_TEST = 1; // smart self-test flag
	localparam int BIT_SMART = 0; // smart flag
	localparam logic [15:0] FEAT_RESET = 16'h008f; // supported after reset
	localparam logic [15:0] FEAT_ABSENT = 16'h0170; // never supported
	localparam logic [7:0] MAKER_COUNT = 8'h00; // arbitrary maker value
	localparam logic [7:0] DH_RESET = 8'ha0; // drive/head after reset

	// taskfile outputs after an overlay command
	typedef struct packed
	{
		logic [7:0] word_index; // refused_word_index
		logic [7:0] bits_upper; // refused_bits_upper
		logic [7:0] bits_lower; // refused_bits_lower
		logic [7:0] count; // maker_defined_count
	} tf_result_t;

	// reallocation request to the media engine
	typedef struct packed
	{
		logic [LBA_W-1:0] lba; // sector to move
		logic from_read; // cause is a read error
	} realloc_req_t;
endpackage : overlay_pkg

// ### rtl/overlay_word_mem.sv
// small word store holding the last received overlay
// assumes one clock; read data are registered, one cycle late
module overlay_word_mem #(
	parameter int DW = 16,
	parameter int DEPTH = 256,
	parameter int AW = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [DW-1:0] wdata_i,
	input wire logic [AW-1:0] raddr_i,
	output logic [DW-1:0] rdata_o
);
	logic [DW-1:0] mem [DEPTH]; // storage, no reset needed

	// write port
	always_ff @(posedge clk_i)
	begin
		if (we_i)
			mem[waddr_i] <= wdata_i;
	end

	// registered read port
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			rdata_o <= '0;
		else
			rdata_o <= mem[raddr_i];
	end
endmodule : overlay_word_mem

// ### rtl/config_overlay_checker.sv
// overlay command checker plus write completion and reallocation control
// assumes all inputs come from logic on core_clk_i; no synchronisers
module config_overlay_checker #(
	parameter logic [7:0] MAKER_VAL = overlay_pkg::MAKER_COUNT
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic ovl_start_i,
	input wire logic ovl_valid_i,
	input wire logic [overlay_pkg::WORD_W-1:0] ovl_data_i,
	output logic ovl_ready_o,
	input wire logic freeze_lock_i,
	input wire logic hpa_set_i,
	input wire logic security_on_i,
	input wire logic smart_on_i,
	input wire logic [overlay_pkg::ADDR_W-1:0] rd_addr_i,
	output logic [overlay_pkg::WORD_W-1:0] rd_data_o,
	input wire logic dh_we_i,
	input wire logic [7:0] dh_data_i,
	output logic [7:0] drive_head_select_o,
	output logic drive_select_bit_o,
	output logic ovl_done_o,
	output logic ovl_abort_o,
	output overlay_pkg::tf_result_t tf_o,
	output logic [overlay_pkg::WORD_W-1:0] feature_word_o,
	input wire logic write_cache_on_i,
	input wire logic wr_start_i,
	input wire logic [overlay_pkg::LBA_W-1:0] wr_lba_i,
	input wire logic host_data_in_i,
	input wire logic media_done_i,
	input wire logic media_err_i,
	input wire logic realloc_done_i,
	input wire logic realloc_fail_i,
	input wire logic rd_fail_i,
	input wire logic rd_recovered_i,
	input wire logic [overlay_pkg::LBA_W-1:0] rd_lba_i,
	output logic wr_complete_o,
	output logic cmd_error_o,
	output logic realloc_valid_o,
	output overlay_pkg::realloc_req_t realloc_o,
	output logic pending_valid_o
);
	import overlay_pkg::*;

	typedef enum logic [1:0] {O_IDLE, O_RECV, O_CHECK} ovl_state_t;
	typedef enum logic [1:0] {W_IDLE, W_DATA, W_MEDIA, W_REALLOC} wr_state_t;

	ovl_state_t ovl_q; // overlay command state
	wr_state_t wr_q; // write command state
	logic [ADDR_W-1:0] cnt_q; // next word index
	logic [7:0] sum_q; // running byte sum
	logic [WORD_W-1:0] w7_q; // received feature word
	logic [7:0] sig_q; // received signature byte
	logic [WORD_W-1:0] feat_q; // applied feature word
	logic [WORD_W-1:0] refuse; // bits that cannot change
	logic integ_ok; // checksum and signature good
	logic abort_d; // overlay outcome
	logic take; // word accepted this cycle
	logic cached_q; // current write ran with cache on
	logic [LBA_W-1:0] wlba_q; // current write sector
	logic err_pend_q; // deferred cached write error
	logic [LBA_W-1:0] pend_lba_q; // sector awaiting reallocation
	logic complete_ev; // any command completion this cycle
	logic wr_fin_ok; // write completes without error
	logic wr_fin_err; // write completes with error
	logic rq_wr; // write side asks for reallocation
	logic pend_hit; // write targets pending sector

	// word handshake
	assign ovl_ready_o = (ovl_q == O_RECV);
	assign take = ovl_ready_o && ovl_valid_i;
	// overlay word store for readback
	overlay_word_mem #(.DW(WORD_W), .DEPTH(OVL_DEPTH), .AW(ADDR_W)) u_mem (
		.clk_i(core_clk_i),
		.rst_i(rst_i),
		.we_i(take),
		.waddr_i(cnt_q),
		.wdata_i(ovl_data_i),
		.raddr_i(rd_addr_i),
		.rdata_o(rd_data_o)
	);
	// overlay sequencing
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ovl_q <= O_IDLE;
			cnt_q <= '0;
		end
		else
		begin
			case (ovl_q)
				O_IDLE:
				begin
					// new command restarts the count
					if (ovl_start_i)
					begin
						ovl_q <= O_RECV;
						cnt_q <= '0;
					end
				end
				O_RECV:
				begin
					if (take)
					begin
						cnt_q <= cnt_q + 8'h01;
						if (cnt_q == LAST_WORD)
							ovl_q <= O_CHECK;
					end
				end
				O_CHECK:
					ovl_q <= O_IDLE;
				default:
					ovl_q <= O_IDLE;
			endcase
		end
	end
	// byte sum over every byte, integrity word included
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			sum_q <= '0;
		else if (ovl_start_i && ovl_q == O_IDLE)
			sum_q <= '0;
		else if (take)
			sum_q <= sum_q + ovl_data_i[15:8] + ovl_data_i[7:0];
	end
	// capture the words that are checked
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			w7_q <= '0;
			sig_q <= '0;
		end
		else if (take)
		begin
			if (cnt_q == FEAT_WORD)
				w7_q <= ovl_data_i;
			if (cnt_q == LAST_WORD)
				sig_q <= ovl_data_i[7:0];
		end
	end
	// integrity check
	assign integ_ok = (sum_q == 8'h00) && (sig_q == SIG_CODE);
	// which feature bits may not take the new value
	always_comb
	begin
		refuse = '0;
		refuse[BIT_LBA48] = w7_q[BIT_LBA48];
		refuse[BIT_AAM] = w7_q[BIT_AAM];
		refuse[BIT_QDMA] = w7_q[BIT_QDMA];
		refuse[BIT_PUIS] = w7_q[BIT_PUIS];
		refuse[BIT_HPA] = !w7_q[BIT_HPA] && feat_q[BIT_HPA] && hpa_set_i;
		refuse[BIT_SEC] = !w7_q[BIT_SEC] && feat_q[BIT_SEC] && security_on_i;
		refuse[BIT_SMART] = !w7_q[BIT_SMART] && feat_q[BIT_SMART]
			&& (w7_q[BIT_LOG] || w7_q[BIT_TEST] || smart_on_i);
	end
	// outcome of the overlay
	assign abort_d = freeze_lock_i || !integ_ok || (refuse != '0);
	// applied feature word, untouched on abort
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			feat_q <= FEAT_RESET;
		else if (ovl_q == O_CHECK && !abort_d)
			feat_q <= w7_q & ~FEAT_ABSENT;
	end
	assign feature_word_o = feat_q;
	// taskfile results and completion pulses
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			tf_o <= '0;
			ovl_done_o <= 1'b0;
			ovl_abort_o <= 1'b0;
		end
		else
		begin
			ovl_done_o <= (ovl_q == O_CHECK);
			ovl_abort_o <= (ovl_q == O_CHECK) && abort_d;
			if (ovl_q == O_CHECK)
			begin
				// refused bits only when a restriction fired; a corrupt overlay is no restriction breach
				tf_o.word_index <= (integ_ok && refuse != '0) ? FEAT_WORD : NO_WORD;
				tf_o.bits_upper <= integ_ok ? refuse[15:8] : 8'h00;
				tf_o.bits_lower <= integ_ok ? refuse[7:0] : 8'h00;
				tf_o.count <= MAKER_VAL;
			end
		end
	end
	// drive/head register written by the host
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			drive_head_select_o <= DH_RESET;
		else if (dh_we_i)
			drive_head_select_o <= dh_data_i;
	end
	assign drive_select_bit_o = drive_head_select_o[4];
	// write command sequencing
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wr_q <= W_IDLE;
			cached_q <= 1'b0;
			wlba_q <= '0;
		end
		else
		begin
			case (wr_q)
				W_IDLE:
				begin
					if (wr_start_i)
					begin
						wr_q <= W_DATA;
						wlba_q <= wr_lba_i;
					end
				end
				W_DATA:
				begin
					// cache mode latched once all data is in
					if (host_data_in_i)
					begin
						wr_q <= W_MEDIA;
						cached_q <= write_cache_on_i;
					end
				end
				W_MEDIA:
					if (media_done_i)
						wr_q <= media_err_i ? W_REALLOC : W_IDLE;
				W_REALLOC:
					if (realloc_done_i || realloc_fail_i)
						wr_q <= W_IDLE;
				default:
					wr_q <= W_IDLE;
			endcase
		end
	end
	// completion points of a write
	assign wr_fin_ok = (wr_q == W_DATA && host_data_in_i && write_cache_on_i)
		|| (!cached_q && wr_q == W_MEDIA && media_done_i && !media_err_i)
		|| (!cached_q && wr_q == W_REALLOC && realloc_done_i);
	assign wr_fin_err = !cached_q && wr_q == W_REALLOC && realloc_fail_i;
	assign complete_ev = wr_fin_ok || wr_fin_err || ovl_q == O_CHECK;
	// deferred error from background reallocation, set wins over clear
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			err_pend_q <= 1'b0;
		else if (cached_q && wr_q == W_REALLOC && realloc_fail_i)
			err_pend_q <= 1'b1;
		else if (complete_ev)
			err_pend_q <= 1'b0;
	end
	// completion and error pulses
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wr_complete_o <= 1'b0;
			cmd_error_o <= 1'b0;
		end
		else
		begin
			wr_complete_o <= wr_fin_ok || wr_fin_err;
			cmd_error_o <= complete_ev && (err_pend_q || wr_fin_err);
		end
	end
	// pending read error sector, a new failure wins over the clear
	assign pend_hit = pending_valid_o && wr_q == W_IDLE && wr_start_i && wr_lba_i == pend_lba_q;
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			pending_valid_o <= 1'b0;
			pend_lba_q <= '0;
		end
		else if (rd_fail_i)
		begin
			pending_valid_o <= 1'b1;
			pend_lba_q <= rd_lba_i;
		end
		else if (pend_hit)
			pending_valid_o <= 1'b0;
	end
	// reallocation requests, write side first
	assign rq_wr = wr_q == W_MEDIA && media_done_i && media_err_i;
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			realloc_valid_o <= 1'b0;
			realloc_o <= '0;
		end
		else
		begin
			realloc_valid_o <= rq_wr || rd_recovered_i || pend_hit;
			if (rq_wr)
				realloc_o <= '{lba: wlba_q, from_read: 1'b0};
			else if (rd_recovered_i)
				realloc_o <= '{lba: rd_lba_i, from_read: 1'b1};
			else if (pend_hit)
				realloc_o <= '{lba: pend_lba_q, from_read: 1'b1};
		end
	end

	// checks of the overlay outcome
	sequence s_check;
		ovl_q == O_CHECK;
	endsequence

	a_freeze_aborts: assert property (@(posedge core_clk_i) disable iff (rst_i)
		s_check and freeze_lock_i |=> ovl_abort_o && ovl_done_o)
		else $error("freeze lock did not abort");
	a_bad_sig_abort: assert property (@(posedge core_clk_i) disable iff (rst_i)
		s_check and sig_q != 8'ha5 |=> ovl_abort_o)
		else $error("bad signature accepted");
	a_sum_aborts: assert property (@(posedge core_clk_i) disable iff (rst_i)
		s_check and sum_q != 8'h00 |=> ovl_abort_o && $stable(feat_q) && tf_o.word_index == 8'h00)
		else $error("bad checksum accepted");
	a_index_on_refuse: assert property (@(posedge core_clk_i) disable iff (rst_i)
		s_check and integ_ok && refuse != 16'h0000 |=> tf_o.word_index == 8'h07 && ovl_abort_o)
		else $error("refused word index wrong");
	a_mask_zero_ok: assert property (@(posedge core_clk_i) disable iff (rst_i)
		ovl_done_o && !ovl_abort_o |-> tf_o.bits_upper == 8'h00 && tf_o.bits_lower == 8'h00)
		else $error("mask not zero on success");
	a_absent_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
		feat_q[8:4] == {1'b0, feat_q[7], 3'b000})
		else $error("unsupported flag set");
	a_hpa_kept: assert property (@(posedge core_clk_i) disable iff (rst_i)
		s_check and hpa_set_i && feat_q[7] && !w7_q[7] |=> ovl_abort_o && feat_q[7])
		else $error("protected area flag cleared");
	a_smart_kept: assert property (@(posedge core_clk_i) disable iff (rst_i)
		s_check and feat_q[0] && !w7_q[0] && (w7_q[1] || smart_on_i) |=> ovl_abort_o)
		else $error("smart flag cleared");
	a_count_maker: assert property (@(posedge core_clk_i) disable iff (rst_i)
		ovl_done_o |-> tf_o.count == MAKER_VAL)
		else $error("count not maker value");

	// write completion timing, reallocation, pending sector and deferred error checks
	sequence s_cached_in;
		wr_q == W_DATA && host_data_in_i && write_cache_on_i;
	endsequence

	a_cache_early: assert property (@(posedge core_clk_i) disable iff (rst_i)
		s_cached_in |=> wr_complete_o ##1 !wr_complete_o)
		else $error("cached write not completed");
	a_nocache_late: assert property (@(posedge core_clk_i) disable iff (rst_i)
		wr_q == W_DATA && host_data_in_i && !write_cache_on_i |=> !wr_complete_o)
		else $error("uncached write completed early");
	a_media_realloc: assert property (@(posedge core_clk_i) disable iff (rst_i)
		wr_q == W_MEDIA && media_done_i && media_err_i |=> realloc_valid_o && !realloc_o.from_read)
		else $error("write error not reallocated");
	a_read_recover: assert property (@(posedge core_clk_i) disable iff (rst_i)
		rd_recovered_i && !rq_wr |=> realloc_valid_o && realloc_o.lba == $past(rd_lba_i))
		else $error("recovered sector not reallocated");
	a_pending_set: assert property (@(posedge core_clk_i) disable iff (rst_i)
		rd_fail_i |=> pending_valid_o && pend_lba_q == $past(rd_lba_i))
		else $error("read error not pending");
	a_deferred_err: assert property (@(posedge core_clk_i) disable iff (rst_i)
		err_pend_q && complete_ev |=> cmd_error_o)
		else $error("deferred error lost");
endmodule : config_overlay_checker

// ### verif/ata_host_model.sv
// host side model: sends one 256 word overlay through the word handshake
// assumes the checker's ready output; drives 1 ns after rising edges
module ata_host_model (
	input wire logic core_clk_i,
	input wire logic ovl_ready_i,
	output logic ovl_start_o,
	output logic ovl_valid_o,
	output logic [overlay_pkg::WORD_W-1:0] ovl_data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import overlay_pkg::*;
	// idle bus
	initial
	begin
		ovl_start_o = 1'b0;
		ovl_valid_o = 1'b0;
		ovl_data_o = 16'h0000;
	end
	// one overlay; bd spoils the checksum on purpose
	task automatic send(input logic [15:0] f, input logic [7:0] sg, input logic bd);
		logic [15:0] w [256];
		logic [7:0] s;
		int i;
		s = 8'h00;
		for (i = 0; i < 255; i++)
		begin
			w[i] = (i == 0) ? 16'h0001 : (i == FEAT_WORD) ? f : 16'($urandom);
			s = s + w[i][15:8] + w[i][7:0];
		end
		s = s + sg;
		w[255] = {(8'h00 - s) ^ {7'h00, bd}, sg};
		@(posedge core_clk_i);
		#1 ovl_start_o = 1'b1;
		@(posedge core_clk_i);
		#1 ovl_start_o = 1'b0;
		for (i = 0; i < 256; i++)
		begin
			ovl_valid_o = 1'b1;
			ovl_data_o = w[i];
			// hold until an edge that sees ready high
			while (ovl_ready_i !== 1'b1)
			begin
				@(posedge core_clk_i);
				#1;
			end
			@(posedge core_clk_i);
			#1;
			// valid drops only for a gap or after the last word, never twice in one time step
			if (i == 255 || $urandom % 5 == 0)
			begin
				ovl_valid_o = 1'b0;
				ovl_data_o = ~w[i]; // released bus shows no stale word
				if (i < 255)
				begin
					@(posedge core_clk_i);
					#1;
				end
			end
		end
	endtask : send
endmodule : ata_host_model

// ### verif/config_overlay_checker_tb.sv
// self-checking bench: overlays, cached/uncached writes, read reallocation
// assumes the host model file; the bench also plays the media engine
module config_overlay_checker_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import overlay_pkg::*;
	localparam logic [7:0] MK = 8'h3c; // maker value under test
	logic core_clk_i = 0, rst_i = 1, st, vl, rdy;
	logic frz = 0, hpa = 0, sec = 0, smt = 0, dh_we = 0, wc = 0, ws = 0, hd = 0, md = 0, me = 0;
	logic rok = 0, rfl = 0, rf = 0, rrec = 0, dsb, dn, ab, wcmp, cerr, rv, pv, def = 0;
	logic [7:0] rd_addr = FEAT_WORD, dh_d = 0, dhs;
	logic [27:0] wl = 0, rl = 0;
	logic [15:0] dat, rdd, fw, cur = FEAT_RESET;
	tf_result_t tf;
	realloc_req_t ro;
	logic [33:0] oq [$]; // expected overlay answers
	logic wq [$]; // expected write completions
	logic [28:0] rq [$]; // expected reallocations
	int n_fail = 0, check_count = 0;
	always #25 core_clk_i = ~core_clk_i;
	config_overlay_checker #(.MAKER_VAL(MK)) config_overlay_checker_inst (.core_clk_i(core_clk_i),
		.rst_i(rst_i), .ovl_start_i(st), .ovl_valid_i(vl), .ovl_data_i(dat), .ovl_ready_o(rdy),
		.freeze_lock_i(frz), .hpa_set_i(hpa), .security_on_i(sec), .smart_on_i(smt), .rd_addr_i(rd_addr),
		.rd_data_o(rdd), .dh_we_i(dh_we), .dh_data_i(dh_d), .drive_head_select_o(dhs),
		.drive_select_bit_o(dsb), .ovl_done_o(dn), .ovl_abort_o(ab), .tf_o(tf), .feature_word_o(fw),
		.write_cache_on_i(wc), .wr_start_i(ws), .wr_lba_i(wl), .host_data_in_i(hd), .media_done_i(md),
		.media_err_i(me), .realloc_done_i(rok), .realloc_fail_i(rfl), .rd_fail_i(rf),
		.rd_recovered_i(rrec), .rd_lba_i(rl), .wr_complete_o(wcmp), .cmd_error_o(cerr),
		.realloc_valid_o(rv), .realloc_o(ro), .pending_valid_o(pv));
	ata_host_model ata_host_model_inst (.core_clk_i(core_clk_i), .ovl_ready_i(rdy), .ovl_start_o(st),
		.ovl_valid_o(vl), .ovl_data_o(dat));
	// compare and count
	task automatic chk(input logic [63:0] s, input logic [63:0] e);
		check_count++;
		if (s !== e)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	// verdict
	task automatic test_done();
		if (n_fail == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done
	// overlay with expected refusal mask worked out from current state
	task automatic ovl(input logic [15:0] f, input logic [7:0] sg, input logic bd, input logic fz);
		logic [15:0] m;
		logic ig;
		logic a;
		m = 16'h0000;
		m[8] = f[8];
		m[6:4] = f[6:4];
		m[7] = cur[7] & ~f[7] & hpa;
		m[3] = cur[3] & ~f[3] & sec;
		m[0] = cur[0] & ~f[0] & (f[1] | f[2] | smt);
		ig = bd | (sg !== SIG_CODE);
		if (ig)
			m = 16'h0000;
		fz = fz & (m == 16'h0000);
		a = ig | fz | (m != 16'h0000);
		oq.push_back({a, (m != 16'h0000) ? FEAT_WORD : NO_WORD, m, MK, def});
		def = 0;
		if (!a)
			cur = f & ~FEAT_ABSENT;
		frz = fz;
		ata_host_model_inst.send(f, sg, bd);
		// send returns just after the edge that took word 255; the check cycle ends at the next edge
		@(posedge core_clk_i);
		#1 chk(dn, 1);
		chk(fw, cur);
		@(posedge core_clk_i);
		#1 chk(dn, 0);
		chk(rdd, f);
	endtask : ovl
	// one write as host and media engine
	task automatic wr(input logic c, input logic e, input logic fl, input logic [27:0] l);
		wc = c;
		ws = 1;
		wl = l;
		@(posedge core_clk_i);
		#1 ws = 0;
		hd = 1;
		if (c)
		begin
			wq.push_back(def);
			def = 0;
		end
		@(posedge core_clk_i);
		#1 hd = 0;
		md = 1;
		me = e;
		if (e)
			rq.push_back({l, 1'b0});
		if (!c && !e)
		begin
			wq.push_back(def);
			def = 0;
		end
		@(posedge core_clk_i);
		#1 md = 0;
		me = 0;
		if (e)
		begin
			@(posedge core_clk_i);
			#1 rok = ~fl;
			rfl = fl;
			if (!c)
			begin
				wq.push_back(fl | def);
				def = 0;
			end
			else
				def = def | fl;
			@(posedge core_clk_i);
			#1 rok = 0;
			rfl = 0;
		end
		repeat (2) @(posedge core_clk_i);
		#1;
	endtask : wr
	// watches results and takes the oldest note of each kind
	always @(posedge core_clk_i)
	begin
		#2;
		if (dn === 1'b1)
		begin
			if (oq.size() == 0)
				chk(1, 0);
			else
				chk({ab, tf, cerr}, oq.pop_front());
		end
		if (wcmp === 1'b1)
		begin
			if (wq.size() == 0)
				chk(1, 0);
			else
				chk(cerr, wq.pop_front());
		end
		if (rv === 1'b1)
		begin
			if (rq.size() == 0)
				chk(1, 0);
			else
				chk(ro, rq.pop_front());
		end
	end
	// watchdog
	initial
	begin
		#(50 * 40000);
		n_fail++;
		test_done();
	end
	// main sequence
	initial
	begin
		logic [15:0] f;
		void'($urandom(32'h97c6));
		repeat (3) @(posedge core_clk_i);
		#1 rst_i = 0;
		chk(dhs, DH_RESET);
		chk(fw, FEAT_RESET);
		dh_we = 1;
		dh_d = 8'($urandom);
		@(posedge core_clk_i);
		#1 dh_we = 0;
		chk(dhs, dh_d);
		chk(dsb, dh_d[4]);
		ovl(16'h008f, SIG_CODE, 0, 0);
		// random overlays against random device state
		repeat (30)
		begin
			f = 16'($urandom) & (($urandom % 2) ? 16'h008f : 16'h01ff);
			hpa = 1'($urandom);
			sec = 1'($urandom);
			smt = 1'($urandom);
			ovl(f, ($urandom % 8 == 0) ? 8'h5a : SIG_CODE, $urandom % 8 == 0, $urandom % 5 == 0);
		end
		repeat (14) wr(1'($urandom), 1'($urandom), 1'($urandom), 28'($urandom));
		// hard read error becomes pending, then fixed by a write
		rl = 28'($urandom);
		rf = 1;
		@(posedge core_clk_i);
		#1 rf = 0;
		chk(pv, 1);
		rq.push_back({rl, 1'b1});
		wr(0, 0, 0, rl);
		chk(pv, 0);
		// recovered read error reallocated at once
		rl = 28'($urandom);
		rrec = 1;
		rq.push_back({rl, 1'b1});
		@(posedge core_clk_i);
		#1 rrec = 0;
		ovl(cur, SIG_CODE, 0, 0);
		repeat (4) @(posedge core_clk_i);
		chk(oq.size() + wq.size() + rq.size(), 0);
		test_done();
	end
endmodule : config_overlay_checker_tb
